// >>> rtl/ccg_pkg.sv
// Package: constants, register map and carrier types for the coulomb counter control
package ccg_pkg;
  // Register byte offsets on APB
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] DITH_OFS   = 12'h004;
  localparam logic [11:0] STAT_OFS   = 12'h008;
  localparam logic [11:0] IRQS_OFS   = 12'h00C;
  localparam logic [11:0] IRQM_OFS   = 12'h010;
  localparam logic [11:0] OFFS_OFS   = 12'h014;
  localparam logic [11:0] INTEG_OFS  = 12'h018;
  localparam logic [11:0] CNTR_OFS   = 12'h01C;
  localparam logic [11:0] ACCUM_OFS  = 12'h020;
  // CTRL field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_CAL_BIT   = 1;
  localparam int CTRL_HOLD_BIT  = 2;
  localparam int CTRL_CLR_BIT   = 3;
  localparam int CTRL_PER_LSB   = 4;
  // DITH field positions
  localparam int DITH_SET_BIT   = 0;
  localparam int DITH_RST_BIT   = 1;
  localparam int DITH_STATE_BIT = 2;
  // Interrupt status bits
  localparam int IRQ_CAL_BIT    = 0;
  localparam int IRQ_RES_BIT    = 1;
  localparam int IRQ_W          = 2;
  // Widths
  localparam int RES_W   = 14;
  localparam int OFS_W   = 10;
  localparam int CNT_W   = 24;
  localparam int ACC_W   = 32;
  localparam int CAL_N   = 8;
  // Integration periods in converter clocks (32.768 kHz): 250, 62.5, 15.6, 3.9 ms
  localparam int CONV_HZ = 32768;
  localparam logic [13:0] PER_250MS  = 14'(CONV_HZ / 4);
  localparam logic [13:0] PER_62MS   = 14'(CONV_HZ / 16);
  localparam logic [13:0] PER_15MS   = 14'(CONV_HZ / 64);
  localparam logic [13:0] PER_3MS    = 14'(CONV_HZ / 256);
  localparam logic [1:0]  PER_RESET  = 2'h0;
  localparam logic [31:0] ERR_DATA   = 32'h0000_0000;

  // Result word from the analog integrator
  typedef struct packed {
    logic             valid;
    logic [RES_W-1:0] value;
  } ccg_result_s;

  typedef enum logic [1:0] {CCG_IDLE, CCG_CAL, CCG_RUN} ccg_state_e;
endpackage

// >>> rtl/ccg_top.sv
// Coulomb counter digital control with APB register file
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ccg_top
  import ccg_pkg::*;
(
  input  wire logic              mclk,          // 32.768 kHz converter clock
  input  wire logic              rst,           // Synchronous reset, active high
  input  wire logic              psel,          // APB select
  input  wire logic              penable,       // APB enable
  input  wire logic              pwrite,        // APB direction
  input  wire logic [11:0]       paddr,         // APB byte address
  input  wire logic [31:0]       pwdata,        // APB write data
  output logic [31:0]            prdata,        // APB read data
  output logic                   pready,        // APB ready
  output logic                   pslverr,       // APB error
  input  wire logic [RES_W-1:0]  adc_result,    // Integrator result, asynchronous
  output logic                   adc_period_end,// Period end strobe to integrator
  output logic                   adc_enable,    // Integrator enable
  output logic                   adc_short,     // Short converter inputs
  output logic                   dither_state,  // Dither enable to analog
  output logic                   irq            // Level interrupt
);

  // Bus decode
  logic        acc;
  logic        wr;
  logic        mapped;
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      CTRL_OFS, DITH_OFS, STAT_OFS, IRQS_OFS, IRQM_OFS,
      OFFS_OFS, INTEG_OFS, CNTR_OFS, ACCUM_OFS: mapped = 1'b1;
      default:                                  mapped = 1'b0;
    endcase
  end
  assign pslverr = acc && !mapped;

  // Result input passes two flops before use
  logic [RES_W-1:0] res_meta_reg;
  logic [RES_W-1:0] res_sync_reg;
  always_ff @(posedge mclk) begin
    res_meta_reg <= adc_result;
    res_sync_reg <= res_meta_reg;
  end

  // Control register
  logic       enable_reg;
  logic       calibration_enable;
  logic       update_hold;
  logic       result_clear_request;
  logic [1:0] period_sel_reg;
  logic       cal_done;
  always_ff @(posedge mclk) begin
    if (rst) begin
      enable_reg     <= 1'b0;
      update_hold    <= 1'b0;
      period_sel_reg <= PER_RESET;
    end else if (wr && paddr == CTRL_OFS) begin
      enable_reg     <= pwdata[CTRL_EN_BIT];
      update_hold    <= pwdata[CTRL_HOLD_BIT];
      period_sel_reg <= pwdata[CTRL_PER_LSB +: 2];
    end
  end
  AST_DEFPER: assert property (@(posedge mclk)
    $fell(rst) |-> period_sel_reg == PER_RESET)
    else $error("period not at default after reset");

  // Calibration enable: set by software, self-clears when done
  always_ff @(posedge mclk) begin
    if (rst)
      calibration_enable <= 1'b0;
    else if (cal_done)
      calibration_enable <= 1'b0;
    else if (wr && paddr == CTRL_OFS && pwdata[CTRL_CAL_BIT])
      calibration_enable <= 1'b1;
  end

  // Clear request lasts one cycle: registers reset on the next edge
  always_ff @(posedge mclk) begin
    if (rst)
      result_clear_request <= 1'b0;
    else
      result_clear_request <= wr && paddr == CTRL_OFS && pwdata[CTRL_CLR_BIT];
  end
  AST_CLRONE: assert property (@(posedge mclk) disable iff (rst)
    result_clear_request |=> !result_clear_request)
    else $error("clear request did not self-clear");

  // Dither state; clear request is deliberately not involved
  logic dither_reg;
  always_ff @(posedge mclk) begin
    if (rst)
      dither_reg <= 1'b0;
    else if (wr && paddr == DITH_OFS && pwdata[DITH_SET_BIT])
      dither_reg <= 1'b1;
    else if (wr && paddr == DITH_OFS && pwdata[DITH_RST_BIT])
      dither_reg <= 1'b0;
  end
  assign dither_state = dither_reg;
  AST_DITHSET: assert property (@(posedge mclk) disable iff (rst)
    (wr && paddr == DITH_OFS && pwdata[DITH_SET_BIT]) |=> dither_state)
    else $error("dither not enabled");
  AST_DITHRST: assert property (@(posedge mclk) disable iff (rst)
    (wr && paddr == DITH_OFS && !pwdata[DITH_SET_BIT] && pwdata[DITH_RST_BIT]) |=> !dither_state)
    else $error("dither not disabled");

  // Period length selection
  function automatic logic [13:0] period_len(input logic [1:0] sel);
    unique case (sel)
      2'h0: period_len = PER_250MS;
      2'h1: period_len = PER_62MS;
      2'h2: period_len = PER_15MS;
      2'h3: period_len = PER_3MS;
    endcase
  endfunction

  // Free-running period timer; restarts with no gap
  logic [13:0] tick_reg;
  logic        period_end;
  assign period_end = enable_reg && (tick_reg >= period_len(period_sel_reg) - 14'h0001);
  always_ff @(posedge mclk) begin
    if (rst || !enable_reg || period_end)
      tick_reg <= 14'h0000;
    else
      tick_reg <= tick_reg + 14'h0001;
  end
  assign adc_period_end = period_end;
  assign adc_enable     = enable_reg;
  AST_RESTART: assert property (@(posedge mclk) disable iff (rst)
    period_end |=> tick_reg == 14'h0000)
    else $error("next period did not start at once");

  // Sequencer: calibration then normal running
  ccg_state_e  state_reg;
  logic [3:0]  cal_cnt_reg;
  logic signed [RES_W+2:0] cal_sum_reg;
  assign cal_done  = state_reg == CCG_CAL && period_end && cal_cnt_reg == 4'(CAL_N - 1);
  assign adc_short = state_reg == CCG_CAL;
  always_ff @(posedge mclk) begin
    if (rst || !enable_reg) begin
      state_reg <= CCG_IDLE;
    end else begin
      unique case (state_reg)
        CCG_IDLE: state_reg <= calibration_enable ? CCG_CAL : CCG_RUN;
        CCG_CAL:  if (cal_done) state_reg <= CCG_RUN;
        CCG_RUN:  if (calibration_enable) state_reg <= CCG_CAL;
      endcase
    end
  end
  AST_IDLE1: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == CCG_IDLE && enable_reg && !wr) |=> state_reg != CCG_IDLE)
    else $error("sequencer stuck in idle");

  // Calibration averaging over eight results
  always_ff @(posedge mclk) begin
    if (rst || state_reg != CCG_CAL) begin
      cal_cnt_reg <= 4'h0;
      cal_sum_reg <= '0;
    end else if (period_end) begin
      cal_cnt_reg <= cal_cnt_reg + 4'h1;
      cal_sum_reg <= cal_sum_reg + (RES_W+3)'($signed(res_sync_reg));
    end
  end

  // Offset store; clear request zeroes it
  logic [OFS_W-1:0] offset_error_value;
  logic signed [RES_W+2:0] cal_final;
  assign cal_final = cal_sum_reg + (RES_W+3)'($signed(res_sync_reg));
  always_ff @(posedge mclk) begin
    if (rst || result_clear_request)
      offset_error_value <= '0;
    else if (cal_done)
      offset_error_value <= cal_final[OFS_W+2:3];
  end
  AST_OFSCLR: assert property (@(posedge mclk) disable iff (rst)
    result_clear_request |=> offset_error_value == '0)
    else $error("offset not cleared");

  // Result, counter and accumulator; hold discards the period
  logic                    take;
  logic [RES_W-1:0]        last_integration_result;
  logic [CNT_W-1:0]        sample_counter;
  logic [ACC_W-1:0]        charge_accumulator;
  ccg_result_s             res_c;
  assign take  = period_end && state_reg == CCG_RUN && !update_hold;
  assign res_c = '{valid: take, value: res_sync_reg};
  always_ff @(posedge mclk) begin
    if (rst)
      last_integration_result <= '0;
    else if (res_c.valid)
      last_integration_result <= res_c.value;
  end
  always_ff @(posedge mclk) begin
    if (rst || result_clear_request) begin
      sample_counter     <= '0;
      charge_accumulator <= '0;
    end else if (res_c.valid) begin
      sample_counter     <= sample_counter + 24'h000001;
      charge_accumulator <= charge_accumulator + ACC_W'($signed(res_c.value));
    end
  end
  AST_DISCARD: assert property (@(posedge mclk) disable iff (rst)
    (period_end && update_hold && !result_clear_request)
    |=> $stable(last_integration_result) && $stable(charge_accumulator))
    else $error("held period not discarded");
  AST_ACC: assert property (@(posedge mclk) disable iff (rst)
    (take && !result_clear_request)
    |=> charge_accumulator == $past(charge_accumulator) + ACC_W'($signed($past(res_sync_reg))))
    else $error("accumulator not updated");

  // Sticky interrupts, write one to clear, set wins
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  assign irq_set = {res_c.valid, cal_done};
  always_ff @(posedge mclk) begin
    if (rst)
      irq_stat_reg <= '0;
    else if (wr && paddr == IRQS_OFS)
      irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end
  AST_W1C: assert property (@(posedge mclk) disable iff (rst)
    (wr && paddr == IRQS_OFS && pwdata[IRQ_CAL_BIT] && !cal_done) |=> !irq_stat_reg[IRQ_CAL_BIT])
    else $error("calibration status not cleared");
  always_ff @(posedge mclk) begin
    if (rst)
      irq_mask_reg <= '0;
    else if (wr && paddr == IRQM_OFS)
      irq_mask_reg <= pwdata[IRQ_W-1:0];
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read mux
  always_comb begin
    prdata = ERR_DATA;
    unique case (paddr)
      CTRL_OFS:  prdata = 32'({period_sel_reg, 1'b0, update_hold,
                               calibration_enable, enable_reg});
      DITH_OFS:  prdata = 32'({dither_reg, 2'b00});
      STAT_OFS:  prdata = 32'(state_reg);
      IRQS_OFS:  prdata = 32'(irq_stat_reg);
      IRQM_OFS:  prdata = 32'(irq_mask_reg);
      OFFS_OFS:  prdata = 32'(offset_error_value);
      INTEG_OFS: prdata = 32'(last_integration_result);
      CNTR_OFS:  prdata = 32'(sample_counter);
      ACCUM_OFS: prdata = charge_accumulator;
      default:   prdata = ERR_DATA;
    endcase
  end

  // Checks
  AST_PERIOD: assert property (@(posedge mclk) disable iff (rst)
    (enable_reg && tick_reg == 14'h0000 && period_sel_reg == 2'h3 && $stable(period_sel_reg))
    |-> ##[1:127] (period_end || period_sel_reg != 2'h3 || !enable_reg))
    else $error("period end missing");
  AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (update_hold && !result_clear_request) |=> $stable(sample_counter))
    else $error("counter moved while held");
  AST_CALCLR: assert property (@(posedge mclk) disable iff (rst)
    cal_done |=> !calibration_enable)
    else $error("calibration enable not cleared");
  AST_CALIRQ: assert property (@(posedge mclk) disable iff (rst)
    cal_done |=> irq_stat_reg[IRQ_CAL_BIT])
    else $error("calibration irq missing");
  AST_RUN: assert property (@(posedge mclk) disable iff (rst)
    (cal_done && enable_reg) |=> state_reg == CCG_RUN)
    else $error("no run after calibration");
  AST_CLR: assert property (@(posedge mclk) disable iff (rst)
    result_clear_request |=> sample_counter == '0 && charge_accumulator == '0)
    else $error("clear failed");
  AST_DITH: assert property (@(posedge mclk) disable iff (rst)
    (result_clear_request && !wr) |=> $stable(dither_reg))
    else $error("dither changed by clear");
  AST_CNT: assert property (@(posedge mclk) disable iff (rst)
    (take && !result_clear_request) |=> sample_counter == $past(sample_counter) + 24'h000001)
    else $error("counter not incremented");
  AST_RES: assert property (@(posedge mclk) disable iff (rst)
    take |=> last_integration_result == $past(res_sync_reg))
    else $error("result not stored");
endmodule

// >>> dv/ccg_integ_model.sv
// Behavioural model of the analog integrator across the sense resistor
`timescale 1ns/1ps
module ccg_integ_model
  import ccg_pkg::*;
#(
  parameter logic [RES_W-1:0] OFS_CODE = 14'h0005  // Offset code seen with inputs shorted
) (
  input  wire logic             mclk,        // Converter clock
  input  wire logic             adc_enable,  // Integrator enable
  input  wire logic             adc_short,   // Inputs shorted for calibration
  input  wire logic [RES_W-1:0] level,       // Signed charge per period, from the bench
  output logic      [RES_W-1:0] adc_result   // Result towards the control logic
);
  logic [RES_W-1:0] idle_pat = 14'h2AAA;
  // Switched-off integrator toggles, so a stale code never passes for a result
  always @(posedge mclk) begin
    idle_pat <= ~idle_pat;
  end
  // Two's complement code, negative while discharging; offset when shorted
  assign adc_result = !adc_enable ? idle_pat :
                      adc_short   ? OFS_CODE : level;
endmodule

// >>> dv/tb.sv
// Self-checking bench for the coulomb counter control
`timescale 1ns/1ps
module tb;
  import ccg_pkg::*;
  logic        mclk    = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [13:0] level   = 14'h0000;
  logic [31:0] prdata, rd, r0, a0;
  logic [13:0] adc_result;
  logic        pready, pslverr, pend, aen, ashort, dith, irq, er;
  int          error_cnt    = 0;
  int          total_checks = 0;
  int          n;
  localparam logic [13:0] PER_TAB [4] = '{PER_250MS, PER_62MS, PER_15MS, PER_3MS};

  ccg_top DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_result(adc_result), .adc_period_end(pend), .adc_enable(aen), .adc_short(ashort),
    .dither_state(dith), .irq(irq));
  ccg_integ_model u_model (.mclk(mclk), .adc_enable(aen), .adc_short(ashort),
    .level(level), .adc_result(adc_result));

  // 10 MHz clock
  always #50 mclk = ~mclk;

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Cycles up to the next period end; a missing pulse counts as a mismatch
  task automatic pulse();
    n = 0;
    do begin @(posedge mclk); n++; end while (pend !== 1'b1 && n < 9000);
    if (n >= 9000) chk(32'h1, 32'h0);
  endtask

  task automatic t_bringup();
    rdc(CTRL_OFS, 32'h3F, 32'h0);
    chk(aen, 1'b0);
    chk(irq, 1'b0);
    apb(1'b1, IRQM_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h30);
    apb(1'b1, CTRL_OFS, 32'h33);
    repeat (4) @(posedge mclk);
    chk(ashort, 1'b1);
    chk(aen, 1'b1);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin @(posedge mclk); n++; end
    chk(irq, 1'b1);
    chk(ashort, 1'b0);
    rdc(OFFS_OFS, 32'h3FF, 32'h005);
    rdc(CTRL_OFS, 32'h2, 32'h0);
    rdc(STAT_OFS, 32'h3, 32'h2);
    apb(1'b1, IRQS_OFS, 32'h1);
    @(posedge mclk);
    chk(irq, 1'b0);
  endtask
  // Clear request right after a period end, then count and sum 3 periods
  task automatic t_measure();
    level <= 14'h3F9C;
    pulse();
    apb(1'b1, CTRL_OFS, 32'h39);
    rdc(OFFS_OFS, 32'hFFFFFFFF, 32'h0);
    rdc(CNTR_OFS, 32'hFFFFFFFF, 32'h0);
    rdc(ACCUM_OFS, 32'hFFFFFFFF, 32'h0);
    rdc(CTRL_OFS, 32'h8, 32'h0);
    pulse();
    apb(1'b0, CNTR_OFS, 32'h0);
    r0 = rd;
    apb(1'b0, ACCUM_OFS, 32'h0);
    a0 = rd;
    repeat (3) pulse();
    apb(1'b0, CNTR_OFS, 32'h0);
    chk(rd - r0, 32'h3);
    apb(1'b0, ACCUM_OFS, 32'h0);
    chk(rd - a0, 32'hFFFFFED4);
    rdc(INTEG_OFS, 32'h3FFF, 32'h3F9C);
    chk(irq, 1'b0);
    apb(1'b1, IRQM_OFS, 32'h3);
    @(posedge mclk);
    chk(irq, 1'b1);
    apb(1'b1, IRQS_OFS, 32'h3);
    @(posedge mclk);
    chk(irq, 1'b0);
    apb(1'b1, IRQM_OFS, 32'h1);
  endtask
  task automatic t_hold();
    apb(1'b1, CTRL_OFS, 32'h35);
    level <= 14'h0032;
    apb(1'b0, CNTR_OFS, 32'h0);
    r0 = rd;
    repeat (2) pulse();
    rdc(CNTR_OFS, 32'hFFFFFFFF, r0);
    rdc(INTEG_OFS, 32'h3FFF, 32'h3F9C);
    apb(1'b1, CTRL_OFS, 32'h31);
    repeat (2) pulse();
    rdc(INTEG_OFS, 32'h3FFF, 32'h0032);
  endtask
  task automatic t_dither();
    apb(1'b1, DITH_OFS, 32'h1);
    @(posedge mclk);
    chk(dith, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h39);
    rdc(DITH_OFS, 32'h4, 32'h4);
    apb(1'b1, DITH_OFS, 32'h2);
    @(posedge mclk);
    chk(dith, 1'b0);
    apb(1'b1, DITH_OFS, 32'h3);
    @(posedge mclk);
    chk(dith, 1'b1);
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    chk(er, 1'b1);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Third interval after each change, so the switch-over period is skipped
  task automatic t_periods();
    for (int s = 3; s >= 0; s--) begin
      apb(1'b1, CTRL_OFS, 32'(s << 4) | 32'h1);
      repeat (3) pulse();
      chk(32'(n), 32'(PER_TAB[s]));
    end
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_bringup();
    t_measure();
    t_hold();
    t_dither();
    t_periods();
    stop_test();
  end
  // Watchdog, sized above the roughly 36000 cycles the tests need
  initial begin
    repeat (45000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end
endmodule
